// ---- verilog/pio_map.sv ----
// Purpose: peripheral register bank behind the data-memory path, F80H..FFFH
// Assumes: one request per cycle from the cpu core on clk_sys, answered next cycle
// Notes: port data registers from FF0H up live elsewhere and are refused here

module pio_map
  import pio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic req,
  input wire logic [11:0] req_addr,
  input wire pio_pkg::pio_acc_t req_kind,
  input wire logic req_write,
  input wire pio_pkg::pio_bop_t req_op,
  input wire logic [1:0] req_bit,
  input wire logic [7:0] req_wdata,
  input wire logic req_carry,
  output logic ack_r,
  output logic refused_r,
  output logic [7:0] rd_data_r,
  output logic bit_res_r,
  input wire logic [7:0] interval_timer_count,
  input wire logic [7:0] serial_shift_in,
  input wire logic [3:0] serial_status,
  input wire logic [3:0] irq_set,
  output logic [7:0] stack_pointer_r,
  output logic [3:0] interval_timer_mode_r,
  output logic [3:0] processor_clock_control_r,
  output logic [3:0] ext_int0_edge_mode_r,
  output logic [3:0] interrupt_enable_flag_r,
  output logic [3:0] interrupt_request_flag_r,
  output logic [3:0] clock_output_mode_r,
  output logic [7:0] pullup_select_group_a_r,
  output logic [7:0] serial_operation_mode_r,
  output logic [7:0] serial_bus_control_r,
  output logic [7:0] serial_shift_data_r,
  output logic serial_shift_load_r,
  output logic [7:0] serial_slave_address_r,
  output logic [7:0] port_direction_group_a_r,
  output logic [7:0] port_direction_group_b_r
);

  // whole module state
  typedef struct packed {
    logic [7:0] sp;
    logic [3:0] interval_timer_mode;
    logic [3:0] processor_clock_control;
    logic [3:0] im0;
    logic [3:0] ie;
    logic [3:0] rq;
    logic [3:0] clock_output_mode;
    logic [7:0] pullup_select_group_a;
    logic [7:0] serial_operation_mode;
    logic [7:0] serial_bus_control;
    logic [7:0] serial_shift_data;
    logic sio_load;
    logic [7:0] serial_slave_address;
    logic [7:0] port_direction_group_a;
    logic [7:0] port_direction_group_b;
    logic [7:0] rd_data;
    logic bit_res;
    logic ack;
    logic refused;
  } pio_state_t;

  pio_state_t state_r, state_nxt;

  // same byte pair as a register base
  function automatic logic same_pair(input logic [11:0] a, input logic [11:0] base);
    same_pair = (a[11:1] == base[11:1]);
  endfunction
  // merge masked bits of a nibble
  function automatic logic [3:0] mrg(input logic [3:0] old, input logic [3:0] d, input logic [3:0] m);
    mrg = (old & ~m) | (d & m);
  endfunction
  // merge into one nibble of a byte
  function automatic logic [7:0] mrg8(input logic [7:0] old, input logic hi, input logic [3:0] d,
                                      input logic [3:0] m);
    if (hi) begin
      mrg8 = {mrg(old[7:4], d, m), old[3:0]};
    end else begin
      mrg8 = {old[7:4], mrg(old[3:0], d, m)};
    end
  endfunction
  // pick one nibble of a byte
  function automatic logic [3:0] pick(input logic [7:0] v, input logic hi);
    pick = hi ? v[7:4] : v[3:0];
  endfunction
  // flag register to interrupt source index
  function automatic logic [2:0] flag_idx(input logic [11:0] a);
    if (a == AD_FLAG_BT) begin
      flag_idx = {1'h1, IRQ_BT};
    end else if (a == AD_FLAG_CSI) begin
      flag_idx = {1'h1, IRQ_CSI};
    end else if (a == AD_FLAG_INT0) begin
      flag_idx = {1'h1, IRQ_INT0};
    end else if (a == AD_FLAG_INT2) begin
      flag_idx = {1'h1, IRQ_INT2};
    end else begin
      flag_idx = {1'h0, IRQ_BT};
    end
  endfunction

  // address decode: allowed widths and bit masks
  function automatic pio_cap_t cap_of(input logic [11:0] a);
    pio_cap_t c;
    c = '0;
    if (a < AD_IO_LO || a > AD_IO_HI) begin
      c = '0;
    end else if (a == AD_BTM || a == AD_PCC || a == AD_IM0 || a == AD_CLOCK_OUTPUT_MODE) begin
      c.nib_w = 1'h1;
      c.wmask = MASK_ALL;
    end else if (a == AD_BT) begin
      c.byte_r = 1'h1;
      c.rmask = MASK_ALL;
    end else if (flag_idx(a) >= {1'h1, IRQ_BT}) begin
      c.bit_ok = 1'h1;
      c.fbit_ok = (a >= AD_FBIT_LO && a <= AD_FBIT_HI);
      c.nib_r = 1'h1;
      c.nib_w = 1'h1;
      c.rmask = MASK_ALL;
      c.wmask = MASK_FLAG;
    end else if (a == AD_SP || a == AD_PULLUP_SELECT_GROUP_A || a == AD_SERIAL_OPERATION_MODE || a == AD_SVA || a == AD_PORT_DIRECTION_GROUP_A || a == AD_PORT_DIRECTION_GROUP_B) begin
      c.byte_w = 1'h1;
      c.wmask = MASK_ALL;
    end else if (a == AD_SERIAL_OPERATION_MODE_HI) begin
      c.bit_ok = 1'h1;
      c.rmask = SERIAL_OPERATION_MODE_HI_R;
      c.wmask = SERIAL_OPERATION_MODE_HI_W;
    end else if (a == AD_SERIAL_BUS_CONTROL_LO) begin
      c.bit_ok = 1'h1;
      c.rmask = SERIAL_BUS_CONTROL_LO_R;
      c.wmask = SERIAL_BUS_CONTROL_LO_W;
    end else if (a == AD_SERIAL_BUS_CONTROL_HI) begin
      c.bit_ok = 1'h1;
      c.rmask = SERIAL_BUS_CONTROL_HI_R;
      c.wmask = SERIAL_BUS_CONTROL_HI_W;
    end else if (a == AD_SIO) begin
      c.byte_r = 1'h1;
      c.byte_w = 1'h1;
      c.rmask = MASK_ALL;
      c.wmask = MASK_ALL;
    end
    cap_of = c;
  endfunction

  // readable view of one nibble address
  function automatic logic [3:0] get_nib(input pio_state_t s, input logic [11:0] a, input logic [7:0] bt,
                                         input logic [7:0] sin, input logic [3:0] st);
    logic [2:0] fi;
    fi = flag_idx(a);
    get_nib = NIB_ZERO;
    if (same_pair(a, AD_BT)) begin
      get_nib = pick(bt, a[0]);
    end else if (fi[2]) begin
      get_nib = {2'h0, s.ie[fi[1:0]], s.rq[fi[1:0]]};
    end else if (a == AD_SERIAL_OPERATION_MODE_HI) begin
      get_nib = {1'h0, st[ST_SERIAL_OPERATION_MODE_B2], 2'h0};
    end else if (a == AD_SERIAL_BUS_CONTROL_LO) begin
      get_nib = {st[ST_SERIAL_BUS_CONTROL_B3], st[ST_SERIAL_BUS_CONTROL_B2], 2'h0};
    end else if (a == AD_SERIAL_BUS_CONTROL_HI) begin
      get_nib = (pick(s.serial_bus_control, 1'h1) & SERIAL_BUS_CONTROL_HI_R & SERIAL_BUS_CONTROL_HI_W) | {1'h0, st[ST_SERIAL_BUS_CONTROL_B6], 2'h0};
    end else if (same_pair(a, AD_SIO)) begin
      get_nib = pick(sin, a[0]);
    end
  endfunction

  // store masked bits into one nibble address
  function automatic pio_state_t put_nib(input pio_state_t s, input logic [11:0] a, input logic [3:0] d,
                                         input logic [3:0] m);
    pio_state_t t;
    logic [2:0] fi;
    t = s;
    fi = flag_idx(a);
    if (same_pair(a, AD_SP)) begin
      t.sp = mrg8(s.sp, a[0], d, m);
      t.sp[SP_FIXED_BIT] = 1'h0;
    end else if (a == AD_BTM) begin
      t.interval_timer_mode = mrg(s.interval_timer_mode, d, m);
    end else if (a == AD_PCC) begin
      t.processor_clock_control = mrg(s.processor_clock_control, d, m);
    end else if (a == AD_IM0) begin
      t.im0 = mrg(s.im0, d, m);
      t.im0[IM0_FIXED_BIT] = 1'h0;
    end else if (fi[2]) begin
      if (m[FLAG_IE_BIT]) begin
        t.ie[fi[1:0]] = d[FLAG_IE_BIT];
      end
      if (m[FLAG_RQ_BIT]) begin
        t.rq[fi[1:0]] = d[FLAG_RQ_BIT];
      end
    end else if (a == AD_CLOCK_OUTPUT_MODE) begin
      t.clock_output_mode = mrg(s.clock_output_mode, d, m);
    end else if (same_pair(a, AD_PULLUP_SELECT_GROUP_A)) begin
      t.pullup_select_group_a = mrg8(s.pullup_select_group_a, a[0], d, m);
    end else if (same_pair(a, AD_SERIAL_OPERATION_MODE)) begin
      t.serial_operation_mode = mrg8(s.serial_operation_mode, a[0], d, m);
    end else if (same_pair(a, AD_SERIAL_BUS_CONTROL_LO)) begin
      t.serial_bus_control = mrg8(s.serial_bus_control, a[0], d, m);
    end else if (same_pair(a, AD_SIO)) begin
      t.serial_shift_data = mrg8(s.serial_shift_data, a[0], d, m);
    end else if (same_pair(a, AD_SVA)) begin
      t.serial_slave_address = mrg8(s.serial_slave_address, a[0], d, m);
    end else if (same_pair(a, AD_PORT_DIRECTION_GROUP_A)) begin
      t.port_direction_group_a = mrg8(s.port_direction_group_a, a[0], d, m);
    end else if (same_pair(a, AD_PORT_DIRECTION_GROUP_B)) begin
      t.port_direction_group_b = mrg8(s.port_direction_group_b, a[0], d, m);
    end
    put_nib = t;
  endfunction

  // next state: one access per cycle, answered by the following edge
  always_comb begin
    pio_cap_t c;
    logic [11:0] hi_addr;
    logic [3:0] onehot;
    logic [3:0] cur;
    logic bit_rd_ok;
    logic bit_wr_ok;
    logic bit_val;
    c = cap_of(req_addr);
    hi_addr = {req_addr[11:1], 1'h1};
    onehot = NIB_ONE << req_bit;
    cur = get_nib(state_r, req_addr, interval_timer_count, serial_shift_in, serial_status);
    bit_rd_ok = |(c.rmask & onehot);
    bit_wr_ok = |(c.wmask & onehot);
    bit_val = |(cur & onehot & c.rmask);
    state_nxt = state_r;
    state_nxt.ack = 1'h0;
    state_nxt.refused = 1'h0;
    state_nxt.sio_load = 1'h0;
    state_nxt.bit_res = 1'h0;
    state_nxt.rd_data = 8'h00;
    if (req) begin
      state_nxt.ack = 1'h1;
      case (req_kind)
        ACC_BYTE: begin
          if (req_addr[0] || !(req_write ? c.byte_w : c.byte_r)) begin
            state_nxt.refused = 1'h1;
          end else if (req_write) begin
            state_nxt = put_nib(state_nxt, req_addr, req_wdata[3:0], MASK_ALL);
            state_nxt = put_nib(state_nxt, hi_addr, req_wdata[7:4], MASK_ALL);
            state_nxt.sio_load = (req_addr == AD_SIO);
          end else begin
            state_nxt.rd_data = {get_nib(state_r, hi_addr, interval_timer_count, serial_shift_in, serial_status),
                                 cur};
          end
        end
        ACC_NIB: begin
          if (!(req_write ? c.nib_w : c.nib_r)) begin
            state_nxt.refused = 1'h1;
          end else if (req_write) begin
            state_nxt = put_nib(state_nxt, req_addr, req_wdata[3:0], c.wmask);
          end else begin
            state_nxt.rd_data = {NIB_ZERO, cur};
          end
        end
        default: begin
          if (req_kind == ACC_MBIT && (!c.bit_ok || req_op > OP_TEST)) begin
            state_nxt.refused = 1'h1;
          end else if (req_kind == ACC_FBIT && !c.fbit_ok) begin
            state_nxt.refused = 1'h1;
          end else begin
            case (req_op)
              OP_SET, OP_CLR: begin
                state_nxt.refused = !bit_wr_ok;
                state_nxt = put_nib(state_nxt, req_addr, (req_op == OP_SET) ? MASK_ALL : NIB_ZERO, onehot & c.wmask);
              end
              OP_TEST, OP_AND, OP_OR, OP_XOR: begin
                state_nxt.refused = !bit_rd_ok;
                state_nxt.bit_res = (req_op == OP_TEST) ? bit_val : (req_op == OP_AND) ? (req_carry & bit_val) :
                                    (req_op == OP_OR) ? (req_carry | bit_val) : (req_carry ^ bit_val);
              end
              OP_TCLR: begin
                state_nxt.refused = !(bit_rd_ok && bit_wr_ok);
                state_nxt.bit_res = bit_val;
                state_nxt = put_nib(state_nxt, req_addr, NIB_ZERO, onehot & c.wmask);
              end
              default: begin
                state_nxt.refused = 1'h1;
              end
            endcase
          end
        end
      endcase
    end
    // request events win over a clear in the same cycle
    state_nxt.rq = state_nxt.rq | irq_set;
  end

  // state register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from state flops
  assign ack_r = state_r.ack;
  assign refused_r = state_r.refused;
  assign rd_data_r = state_r.rd_data;
  assign bit_res_r = state_r.bit_res;
  assign stack_pointer_r = state_r.sp;
  assign interval_timer_mode_r = state_r.interval_timer_mode;
  assign processor_clock_control_r = state_r.processor_clock_control;
  assign ext_int0_edge_mode_r = state_r.im0;
  assign interrupt_enable_flag_r = state_r.ie;
  assign interrupt_request_flag_r = state_r.rq;
  assign clock_output_mode_r = state_r.clock_output_mode;
  assign pullup_select_group_a_r = state_r.pullup_select_group_a;
  assign serial_operation_mode_r = state_r.serial_operation_mode;
  assign serial_bus_control_r = state_r.serial_bus_control;
  assign serial_shift_data_r = state_r.serial_shift_data;
  assign serial_shift_load_r = state_r.sio_load;
  assign serial_slave_address_r = state_r.serial_slave_address;
  assign port_direction_group_a_r = state_r.port_direction_group_a;
  assign port_direction_group_b_r = state_r.port_direction_group_b;

endmodule

// ---- common/pio_pkg.sv ----
// Purpose: shared constants and types for the peripheral register map decode
// Assumes: 12-bit data-memory addresses, 4-bit nibble storage per address
// Notes: byte registers are addressed by their even nibble address
package pio_pkg;

  // peripheral window limits
  localparam logic [11:0] AD_IO_LO = 12'hF80;
  localparam logic [11:0] AD_IO_HI = 12'hFFF;
  localparam logic [11:0] AD_FBIT_LO = 12'hFB0;
  localparam logic [11:0] AD_FBIT_HI = 12'hFBF;

  // register addresses
  localparam logic [11:0] AD_SP = 12'hF80;
  localparam logic [11:0] AD_BTM = 12'hF85;
  localparam logic [11:0] AD_BT = 12'hF86;
  localparam logic [11:0] AD_PCC = 12'hFB3;
  localparam logic [11:0] AD_IM0 = 12'hFB4;
  localparam logic [11:0] AD_FLAG_BT = 12'hFB8;
  localparam logic [11:0] AD_FLAG_CSI = 12'hFBD;
  localparam logic [11:0] AD_FLAG_INT0 = 12'hFBE;
  localparam logic [11:0] AD_FLAG_INT2 = 12'hFBF;
  localparam logic [11:0] AD_CLOCK_OUTPUT_MODE = 12'hFD0;
  localparam logic [11:0] AD_PULLUP_SELECT_GROUP_A = 12'hFDC;
  localparam logic [11:0] AD_SERIAL_OPERATION_MODE = 12'hFE0;
  localparam logic [11:0] AD_SERIAL_OPERATION_MODE_HI = 12'hFE1;
  localparam logic [11:0] AD_SERIAL_BUS_CONTROL_LO = 12'hFE2;
  localparam logic [11:0] AD_SERIAL_BUS_CONTROL_HI = 12'hFE3;
  localparam logic [11:0] AD_SIO = 12'hFE4;
  localparam logic [11:0] AD_SVA = 12'hFE6;
  localparam logic [11:0] AD_PORT_DIRECTION_GROUP_A = 12'hFE8;
  localparam logic [11:0] AD_PORT_DIRECTION_GROUP_B = 12'hFEC;

  // fixed bits and flag layout
  localparam int unsigned SP_FIXED_BIT = 0;
  localparam int unsigned IM0_FIXED_BIT = 2;
  localparam int unsigned FLAG_IE_BIT = 1;
  localparam int unsigned FLAG_RQ_BIT = 0;

  // interrupt source indices
  localparam int unsigned IRQ_N = 4;
  localparam logic [1:0] IRQ_BT = 2'h0;
  localparam logic [1:0] IRQ_CSI = 2'h1;
  localparam logic [1:0] IRQ_INT0 = 2'h2;
  localparam logic [1:0] IRQ_INT2 = 2'h3;

  // serial status input lanes
  localparam int unsigned ST_SERIAL_OPERATION_MODE_B2 = 0;
  localparam int unsigned ST_SERIAL_BUS_CONTROL_B2 = 1;
  localparam int unsigned ST_SERIAL_BUS_CONTROL_B3 = 2;
  localparam int unsigned ST_SERIAL_BUS_CONTROL_B6 = 3;

  // per-bit access masks
  localparam logic [3:0] MASK_ALL = 4'hF;
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [3:0] MASK_FLAG = 4'h3;
  localparam logic [3:0] SERIAL_OPERATION_MODE_HI_R = 4'h4;
  localparam logic [3:0] SERIAL_OPERATION_MODE_HI_W = 4'hA;
  localparam logic [3:0] SERIAL_BUS_CONTROL_LO_R = 4'hC;
  localparam logic [3:0] SERIAL_BUS_CONTROL_LO_W = 4'h3;
  localparam logic [3:0] SERIAL_BUS_CONTROL_HI_R = 4'hE;
  localparam logic [3:0] SERIAL_BUS_CONTROL_HI_W = 4'hB;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] NIB_ONE = 4'h1;

  // access kinds and bit operations
  typedef enum logic [1:0] {ACC_MBIT = 2'h0, ACC_FBIT = 2'h1, ACC_NIB = 2'h2, ACC_BYTE = 2'h3} pio_acc_t;
  typedef enum logic [2:0] {
    OP_SET = 3'h0, OP_CLR = 3'h1, OP_TEST = 3'h2, OP_AND = 3'h3,
    OP_OR = 3'h4, OP_XOR = 3'h5, OP_TCLR = 3'h6
  } pio_bop_t;

  // what an address allows
  typedef struct packed {
    logic bit_ok;
    logic fbit_ok;
    logic nib_r;
    logic nib_w;
    logic byte_r;
    logic byte_w;
    logic [3:0] rmask;
    logic [3:0] wmask;
  } pio_cap_t;

endpackage

// ---- dv/pio_map_asserts.sv ----
// Purpose: port checks for the peripheral register map
// Assumes: one clock, synchronous active-high reset
// Notes: bound to pio_map below
module pio_map_asserts
  import pio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic req,
  input wire logic [11:0] req_addr,
  input wire pio_pkg::pio_acc_t req_kind,
  input wire logic req_write,
  input wire logic [7:0] req_wdata,
  input wire logic ack_r,
  input wire logic refused_r,
  input wire logic [7:0] stack_pointer_r,
  input wire logic [3:0] ext_int0_edge_mode_r,
  input wire logic serial_shift_load_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // access steps: byte write taken, refusal answered
  sequence s_sp_wr;
    req && req_addr == AD_SP && req_kind == ACC_BYTE && req_write;
  endsequence
  sequence s_sio_wr;
    req && req_addr == AD_SIO && req_kind == ACC_BYTE && req_write;
  endsequence
  sequence s_refused;
    ack_r && refused_r;
  endsequence
  a_ack_next: assert property (req |=> ack_r)
    else $error("no answer one cycle after a request");
  a_sp_lsb_zero: assert property (stack_pointer_r[SP_FIXED_BIT] == 1'h0)
    else $error("stack pointer bit 0 set");
  a_sp_byte_load: assert property (s_sp_wr |=> !refused_r && stack_pointer_r == {$past(req_wdata[7:1]), 1'h0})
    else $error("stack pointer byte write wrong");
  a_sp_nib_refuse: assert property (req && req_addr == AD_SP && req_kind != ACC_BYTE |=> s_refused ##0 $stable(stack_pointer_r))
    else $error("stack pointer narrow access not refused");
  a_im0_bit_zero: assert property (ext_int0_edge_mode_r[IM0_FIXED_BIT] == 1'h0)
    else $error("edge mode bit 2 set");
  a_im0_no_read: assert property (req && req_addr == AD_IM0 && !req_write && req_kind == ACC_NIB |=> s_refused)
    else $error("edge mode read not refused");
  a_out_of_map: assert property (req && req_addr < AD_IO_LO |=> s_refused)
    else $error("address below window not refused");
  a_odd_byte: assert property (req && req_kind == ACC_BYTE && req_addr[0] |=> s_refused)
    else $error("odd byte address not refused");
  a_sio_load: assert property (s_sio_wr |=> serial_shift_load_r && !refused_r)
    else $error("shift load pulse missing");
endmodule

bind pio_map pio_map_asserts pio_map_asserts_i (.clk_sys(clk_sys), .reset(reset), .req(req),
  .req_addr(req_addr), .req_kind(req_kind), .req_write(req_write), .req_wdata(req_wdata),
  .ack_r(ack_r), .refused_r(refused_r), .stack_pointer_r(stack_pointer_r),
  .ext_int0_edge_mode_r(ext_int0_edge_mode_r), .serial_shift_load_r(serial_shift_load_r));

// ---- dv/pio_cpu_model.sv ----
// Purpose: cpu core data-memory path issuing single accesses
// Assumes: answer one cycle after the taking edge
// Notes: released address and data show the inverted value
module pio_cpu_model
  import pio_pkg::*;
(
  input wire logic clk_sys,
  input wire logic ack_r,
  output logic req,
  output logic [11:0] req_addr,
  output pio_pkg::pio_acc_t req_kind,
  output logic req_write,
  output pio_pkg::pio_bop_t req_op,
  output logic [1:0] req_bit,
  output logic [7:0] req_wdata,
  output logic req_carry
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero
  initial begin
    req = 1'h0;
    req_addr = 12'h000;
    req_kind = ACC_NIB;
    req_write = 1'h0;
    req_op = OP_SET;
    req_bit = 2'h0;
    req_wdata = 8'h00;
    req_carry = 1'h0;
  end
  task automatic acc(input logic [11:0] a, input pio_acc_t k, input logic w, input pio_bop_t op,
      input logic [1:0] b, input logic [7:0] d, input logic c, output logic ok);
    ok = 1'h0;
    @(posedge clk_sys);
    req <= 1'h1;
    req_addr <= a;
    req_kind <= k;
    req_write <= w;
    req_op <= op;
    req_bit <= b;
    req_wdata <= d;
    req_carry <= c;
    @(posedge clk_sys);
    req <= 1'h0;
    req_addr <= ~a;
    req_wdata <= ~d;
    req_carry <= ~c;
    // bounded wait for the answer
    for (int n = 0; n < 4 && !ok; n++) begin
      #1;
      if (ack_r === 1'h1) ok = 1'h1;
      else @(posedge clk_sys);
    end
  endtask
endmodule

// ---- dv/pio_map_tb_top.sv ----
// Purpose: directed bench for the peripheral register map
// Assumes: partner model issues accesses, bench drives status inputs
// Notes: checks taken in the answer cycle
module pio_map_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pio_pkg::*;
  logic clk_sys, reset, req, req_write, req_carry, ack_r, refused_r, bit_res_r, serial_shift_load_r, ok;
  logic [11:0] req_addr;
  pio_acc_t req_kind;
  pio_bop_t req_op;
  logic [1:0] req_bit;
  logic [7:0] req_wdata, rd_data_r, interval_timer_count, serial_shift_in, stack_pointer_r;
  logic [3:0] serial_status, irq_set, interval_timer_mode_r, processor_clock_control_r;
  logic [3:0] ext_int0_edge_mode_r, interrupt_enable_flag_r, interrupt_request_flag_r, clock_output_mode_r;
  logic [7:0] pullup_select_group_a_r, serial_operation_mode_r, serial_bus_control_r, serial_shift_data_r;
  logic [7:0] serial_slave_address_r, port_direction_group_a_r, port_direction_group_b_r;
  logic [11:0] fa [4] = '{AD_FLAG_BT, AD_FLAG_CSI, AD_FLAG_INT0, AD_FLAG_INT2};
  int n_fail = 0;
  int total_checks = 0;
  pio_map pio_map_i (.*);
  pio_cpu_model pio_cpu_model_i (.*);
  // 50 MHz clock
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // value and flag comparisons
  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // one access, then the refusal flag
  task automatic go(input logic [11:0] a, input pio_acc_t k, input logic w, input pio_bop_t op,
      input logic [1:0] b, input logic [7:0] d, input logic c, input logic rf);
    pio_cpu_model_i.acc(a, k, w, op, b, d, c, ok);
    if (ok !== 1'h1) begin
      n_fail++;
      $display("Error %0t no answer", $time);
      close_out();
    end else chk_f(refused_r, rf);
  endtask
  task automatic wr(input logic [11:0] a, input pio_acc_t k, input logic [7:0] d, input logic rf);
    go(a, k, 1'h1, OP_SET, 2'h0, d, 1'h0, rf);
  endtask
  task automatic rd(input logic [11:0] a, input pio_acc_t k, input logic rf);
    go(a, k, 1'h0, OP_SET, 2'h0, 8'h00, 1'h0, rf);
  endtask
  task automatic bop(input logic [11:0] a, input pio_acc_t k, input pio_bop_t op, input logic [1:0] b,
      input logic c, input logic rf);
    go(a, k, 1'h0, op, b, 8'h00, c, rf);
  endtask
  // main sequence
  initial begin
    reset = 1'h1;
    irq_set = 4'h0;
    serial_status = 4'h0;
    interval_timer_count = 8'h00;
    serial_shift_in = 8'h00;
    repeat (5) @(posedge clk_sys);
    reset <= 1'h0;
    interval_timer_count <= 8'h3C;
    serial_shift_in <= 8'hC3;
    serial_status <= 4'h2;
    @(posedge clk_sys);
    #1;
    chk_f(ack_r, 1'h0);
    wr(AD_SP, ACC_BYTE, 8'h41, 1'h0);
    chk_v(stack_pointer_r, 8'h40);
    wr(AD_SP, ACC_BYTE, 8'hFF, 1'h0);
    chk_v(stack_pointer_r, 8'hFE);
    wr(AD_SP, ACC_NIB, 8'h05, 1'h1);
    rd(AD_SP, ACC_BYTE, 1'h1);
    chk_v(stack_pointer_r, 8'hFE);
    wr(12'hF81, ACC_BYTE, 8'h00, 1'h1);
    rd(12'h020, ACC_NIB, 1'h1);
    rd(12'hFB2, ACC_NIB, 1'h1);
    rd(12'hFF0, ACC_NIB, 1'h1);
    wr(AD_BTM, ACC_NIB, 8'h07, 1'h0);
    chk_v({4'h0, interval_timer_mode_r}, 8'h07);
    rd(AD_BTM, ACC_NIB, 1'h1);
    wr(AD_IM0, ACC_NIB, 8'h0F, 1'h0);
    chk_v({4'h0, ext_int0_edge_mode_r}, 8'h0B);
    rd(AD_IM0, ACC_NIB, 1'h1);
    wr(AD_PCC, ACC_NIB, 8'h09, 1'h0);
    chk_v({4'h0, processor_clock_control_r}, 8'h09);
    wr(AD_CLOCK_OUTPUT_MODE, ACC_NIB, 8'h06, 1'h0);
    chk_v({4'h0, clock_output_mode_r}, 8'h06);
    rd(AD_BT, ACC_BYTE, 1'h0);
    chk_v(rd_data_r, 8'h3C);
    wr(AD_BT, ACC_BYTE, 8'h00, 1'h1);
    wr(AD_PULLUP_SELECT_GROUP_A, ACC_BYTE, 8'h5C, 1'h0);
    chk_v(pullup_select_group_a_r, 8'h5C);
    wr(AD_PORT_DIRECTION_GROUP_A, ACC_BYTE, 8'hA3, 1'h0);
    chk_v(port_direction_group_a_r, 8'hA3);
    wr(AD_PORT_DIRECTION_GROUP_B, ACC_BYTE, 8'h3A, 1'h0);
    chk_v(port_direction_group_b_r, 8'h3A);
    wr(AD_SVA, ACC_BYTE, 8'hC5, 1'h0);
    chk_v(serial_slave_address_r, 8'hC5);
    wr(AD_SERIAL_OPERATION_MODE, ACC_BYTE, 8'h8E, 1'h0);
    chk_v(serial_operation_mode_r, 8'h8E);
    wr(AD_SIO, ACC_BYTE, 8'h5A, 1'h0);
    chk_f(serial_shift_load_r, 1'h1);
    chk_v(serial_shift_data_r, 8'h5A);
    rd(AD_SIO, ACC_BYTE, 1'h0);
    chk_v(rd_data_r, 8'hC3);
    // timer request event, then flag operations
    @(posedge clk_sys) irq_set <= 4'h1;
    @(posedge clk_sys) irq_set <= 4'h0;
    #1;
    chk_v({4'h0, interrupt_request_flag_r}, 8'h01);
    for (int i = 0; i < 4; i++) bop(fa[i], ACC_FBIT, OP_SET, 2'h1, 1'h0, 1'h0);
    chk_v({4'h0, interrupt_enable_flag_r}, 8'h0F);
    bop(AD_FLAG_BT, ACC_MBIT, OP_TEST, 2'h0, 1'h0, 1'h0);
    chk_f(bit_res_r, 1'h1);
    bop(AD_FLAG_BT, ACC_FBIT, OP_AND, 2'h1, 1'h1, 1'h0);
    chk_f(bit_res_r, 1'h1);
    bop(AD_FLAG_BT, ACC_FBIT, OP_XOR, 2'h1, 1'h1, 1'h0);
    chk_f(bit_res_r, 1'h0);
    bop(AD_FLAG_BT, ACC_FBIT, OP_TCLR, 2'h0, 1'h0, 1'h0);
    chk_f(bit_res_r, 1'h1);
    chk_v({4'h0, interrupt_request_flag_r}, 8'h00);
    bop(AD_FLAG_BT, ACC_FBIT, OP_OR, 2'h1, 1'h0, 1'h0);
    chk_f(bit_res_r, 1'h1);
    rd(AD_FLAG_BT, ACC_NIB, 1'h0);
    chk_v(rd_data_r, 8'h02);
    bop(AD_FLAG_BT, ACC_MBIT, OP_CLR, 2'h1, 1'h0, 1'h0);
    chk_v({4'h0, interrupt_enable_flag_r}, 8'h0E);
    bop(AD_FLAG_BT, ACC_MBIT, OP_AND, 2'h1, 1'h1, 1'h1);
    bop(AD_SERIAL_OPERATION_MODE_HI, ACC_FBIT, OP_SET, 2'h3, 1'h0, 1'h1);
    bop(AD_SERIAL_BUS_CONTROL_LO, ACC_MBIT, OP_TEST, 2'h2, 1'h0, 1'h0);
    chk_f(bit_res_r, 1'h1);
    // serial control bits: writable, read-only and mixed lanes
    bop(AD_SERIAL_BUS_CONTROL_LO, ACC_MBIT, OP_SET, 2'h0, 1'h0, 1'h0);
    bop(AD_SERIAL_BUS_CONTROL_HI, ACC_MBIT, OP_SET, 2'h3, 1'h0, 1'h0);
    bop(AD_SERIAL_BUS_CONTROL_LO, ACC_MBIT, OP_SET, 2'h3, 1'h0, 1'h1);
    chk_v(serial_bus_control_r, 8'h81);
    bop(AD_SERIAL_BUS_CONTROL_HI, ACC_MBIT, OP_TEST, 2'h3, 1'h0, 1'h0);
    chk_f(bit_res_r, 1'h1);
    bop(AD_SERIAL_OPERATION_MODE_HI, ACC_MBIT, OP_CLR, 2'h3, 1'h0, 1'h0);
    chk_v(serial_operation_mode_r, 8'h0E);
    close_out();
  end
endmodule
